// file: rtl/sft_active.sv
// Active end: issues fetch requests and collects the returned data
// Notes on behaviour
// - Request frame carries header only, no data
// - Responder checks header, fetches, answers with data
// - Over 128 bytes: continuation request after each response but the last
// - Continuation request carries four header bytes only
// - Continuation header is FF 00 45 44
// - Each continuation answered with next data portion
// - Non-zero error number means no user data
// - Error number for bad reception or header
// - Frame ends DLE ETX, optional check, then acknowledge
// - Only one command outstanding at a time
`timescale 1ns/1ns
`include "sft_params.svh"

module sft_active (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Link
  sft_link_if.active       link,
  // Configuration
  input  wire logic        bcc_en,
  // Request
  input  wire logic        start,
  input  wire logic [7:0]  req_db,
  input  wire logic [7:0]  req_off,
  input  wire logic [15:0] req_len,
  // Result
  output logic             busy,
  output logic             data_valid,
  output logic [7:0]       data,
  output logic             done,
  output logic [7:0]       err_num,
  output logic             proto_err
);

  sft_pkg::sft_act_state_e state;
  logic [3:0]  cnt;
  logic [7:0]  dcnt;
  logic [7:0]  bcc;
  logic [7:0]  db;
  logic [7:0]  off;
  logic [15:0] len;
  logic [15:0] rem;
  logic        first;
  logic        tx_valid;
  logic [7:0]  tx_data;
  logic [3:0]  hlen;
  logic [7:0]  hdr;
  logic [7:0]  chunk;
  logic        rx;
  logic [7:0]  rb;

  // ****************************************
  // Request header bytes
  // ****************************************
  function automatic logic [7:0] hdr_byte(input logic [3:0] idx, input logic fst, input logic [7:0] d,
                                          input logic [7:0] o, input logic [15:0] l);
    unique case (idx)
      4'h0:    return fst ? `SFT_FIRST : `SFT_CONT;
      4'h1:    return 8'h00;
      4'h2:    return `SFT_CMD_FETCH;
      4'h3:    return `SFT_DATA_BLK;
      4'h4:    return d;
      4'h5:    return o;
      4'h6:    return l[15:8];
      4'h7:    return l[7:0];
      default: return `SFT_NO_COORD;
    endcase
  endfunction : hdr_byte

  assign hlen  = first ? `SFT_HDR_FULL : `SFT_HDR_CONT;
  assign hdr   = hdr_byte(cnt, first, db, off, len);
  assign chunk = sft_pkg::chunk_len(rem);
  assign rx    = link.p2a_valid;
  assign rb    = link.p2a_data;
  assign busy  = (state != sft_pkg::ACT_IDLE);

  assign link.a2p_valid = tx_valid;
  assign link.a2p_data  = tx_data;

  // ****************************************
  // Frame sequencer
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state      <= sft_pkg::ACT_IDLE;
      cnt        <= 4'h0;
      dcnt       <= 8'h00;
      bcc        <= 8'h00;
      db         <= 8'h00;
      off        <= 8'h00;
      len        <= 16'h0000;
      rem        <= 16'h0000;
      first      <= 1'b0;
      tx_valid   <= 1'b0;
      tx_data    <= 8'h00;
      data_valid <= 1'b0;
      data       <= 8'h00;
      done       <= 1'b0;
      err_num    <= 8'h00;
      proto_err  <= 1'b0;
    end else begin
      tx_valid   <= 1'b0;
      data_valid <= 1'b0;
      done       <= 1'b0;
      unique case (state)
        sft_pkg::ACT_IDLE: begin
          if (start) begin
            rem       <= req_len;
            len       <= req_len;
            db        <= req_db;
            off       <= req_off;
            first     <= 1'b1;
            err_num   <= `SFT_ERR_NONE;
            proto_err <= 1'b0;
            state     <= sft_pkg::ACT_TX_STX;
          end
        end
        sft_pkg::ACT_TX_STX: begin
          tx_valid <= 1'b1;
          tx_data  <= `SFT_STX;
          cnt      <= 4'h0;
          bcc      <= 8'h00;
          state    <= sft_pkg::ACT_W_ACK1;
        end
        sft_pkg::ACT_W_ACK1: begin
          if (rx) begin
            proto_err <= (rb != `SFT_DLE);
            state     <= (rb == `SFT_DLE) ? sft_pkg::ACT_TX_HDR : sft_pkg::ACT_FIN;
          end
        end
        sft_pkg::ACT_TX_HDR: begin
          tx_valid <= 1'b1;
          tx_data  <= hdr;
          bcc      <= bcc ^ hdr;
          cnt      <= cnt + 4'h1;
          if (cnt == hlen - 4'h1) begin
            state <= sft_pkg::ACT_TX_DLE;
          end
        end
        sft_pkg::ACT_TX_DLE: begin
          tx_valid <= 1'b1;
          tx_data  <= `SFT_DLE;
          bcc      <= bcc ^ `SFT_DLE;
          state    <= sft_pkg::ACT_TX_ETX;
        end
        sft_pkg::ACT_TX_ETX: begin
          tx_valid <= 1'b1;
          tx_data  <= `SFT_ETX;
          bcc      <= bcc ^ `SFT_ETX;
          state    <= bcc_en ? sft_pkg::ACT_TX_BCC : sft_pkg::ACT_W_ACK2;
        end
        sft_pkg::ACT_TX_BCC: begin
          tx_valid <= 1'b1;
          tx_data  <= bcc;
          state    <= sft_pkg::ACT_W_ACK2;
        end
        sft_pkg::ACT_W_ACK2: begin
          if (rx) begin
            proto_err <= (rb != `SFT_DLE);
            state     <= (rb == `SFT_DLE) ? sft_pkg::ACT_R_STX : sft_pkg::ACT_FIN;
          end
        end
        sft_pkg::ACT_R_STX: begin
          if (rx) begin
            if (rb == `SFT_STX) begin
              tx_valid <= 1'b1;
              tx_data  <= `SFT_DLE;
              cnt      <= 4'h0;
              bcc      <= 8'h00;
              state    <= sft_pkg::ACT_R_HDR;
            end else begin
              proto_err <= 1'b1;
              state     <= sft_pkg::ACT_FIN;
            end
          end
        end
        sft_pkg::ACT_R_HDR: begin
          if (rx) begin
            bcc <= bcc ^ rb;
            cnt <= cnt + 4'h1;
            if (cnt == `SFT_RSP_HDR - 4'h1) begin
              err_num <= rb;
              dcnt    <= (rb != `SFT_ERR_NONE) ? 8'h00 : chunk;
              state   <= (rb != `SFT_ERR_NONE || chunk == 8'h00) ? sft_pkg::ACT_R_DLE : sft_pkg::ACT_R_DATA;
            end
          end
        end
        sft_pkg::ACT_R_DATA: begin
          if (rx) begin
            bcc        <= bcc ^ rb;
            data_valid <= 1'b1;
            data       <= rb;
            dcnt       <= dcnt - 8'h01;
            if (dcnt == 8'h01) begin
              state <= sft_pkg::ACT_R_DLE;
            end
          end
        end
        sft_pkg::ACT_R_DLE: begin
          if (rx) begin
            bcc       <= bcc ^ rb;
            proto_err <= (rb != `SFT_DLE);
            state     <= (rb == `SFT_DLE) ? sft_pkg::ACT_R_ETX : sft_pkg::ACT_FIN;
          end
        end
        sft_pkg::ACT_R_ETX: begin
          if (rx) begin
            bcc       <= bcc ^ rb;
            proto_err <= (rb != `SFT_ETX);
            if (rb != `SFT_ETX) begin
              state <= sft_pkg::ACT_FIN;
            end else begin
              state <= bcc_en ? sft_pkg::ACT_R_BCC : sft_pkg::ACT_TX_ACK;
            end
          end
        end
        sft_pkg::ACT_R_BCC: begin
          if (rx) begin
            proto_err <= (rb != bcc);
            state     <= (rb == bcc) ? sft_pkg::ACT_TX_ACK : sft_pkg::ACT_FIN;
          end
        end
        sft_pkg::ACT_TX_ACK: begin
          tx_valid <= 1'b1;
          tx_data  <= `SFT_DLE;
          if (err_num != `SFT_ERR_NONE || rem == {8'h00, chunk}) begin
            state <= sft_pkg::ACT_FIN;
          end else begin
            rem   <= rem - {8'h00, chunk};
            first <= 1'b0;
            state <= sft_pkg::ACT_TX_STX;
          end
        end
        sft_pkg::ACT_FIN: begin
          done  <= 1'b1;
          state <= sft_pkg::ACT_IDLE;
        end
      endcase
    end
  end

endmodule : sft_active

// file: rtl/sft_link_if.sv
// Byte link between the active and the passive end
`timescale 1ns/1ns

interface sft_link_if;
  logic       a2p_valid;
  logic [7:0] a2p_data;
  logic       p2a_valid;
  logic [7:0] p2a_data;

  modport active  (output a2p_valid, output a2p_data, input p2a_valid, input p2a_data);
  modport passive (input a2p_valid, input a2p_data, output p2a_valid, output p2a_data);
endinterface : sft_link_if

// file: rtl/sft_params.svh
// Constants of the fetch transaction framer: codes, header lengths, chunk size, error numbers
`ifndef SFT_PARAMS_SVH
`define SFT_PARAMS_SVH

// ****************************************
// Link control codes
// ****************************************
`define SFT_STX       8'h02
`define SFT_DLE       8'h10
`define SFT_ETX       8'h03

// ****************************************
// Header codes
// ****************************************
`define SFT_FIRST     8'h00
`define SFT_CONT      8'hFF
`define SFT_CMD_FETCH 8'h45
`define SFT_DATA_BLK  8'h44
`define SFT_NO_COORD  8'hFF

// ****************************************
// Frame sizes
// ****************************************
`define SFT_HDR_FULL  4'hA
`define SFT_HDR_CONT  4'h4
`define SFT_RSP_HDR   4'h4
`define SFT_CHUNK     16'h0080

// ****************************************
// Error numbers
// ****************************************
`define SFT_ERR_NONE  8'h00
`define SFT_ERR_HDR   8'h0A
`define SFT_ERR_BCC   8'h0C
`define SFT_ERR_NODAT 8'h0E

`endif

// file: rtl/sft_passive.sv
// Passive end: answers fetch requests with data read from the local store
`timescale 1ns/1ns
`include "sft_params.svh"

module sft_passive (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Link
  sft_link_if.passive      link,
  // Configuration
  input  wire logic        bcc_en,
  // Data source
  output logic             rd_req,
  output logic [7:0]       rd_db,
  output logic [15:0]      rd_addr,
  input  wire logic        rd_valid,
  input  wire logic [7:0]  rd_data,
  // Status
  output logic             req_done,
  output logic [7:0]       err_num
);

  sft_pkg::sft_pas_state_e state;
  logic [3:0]  cnt;
  logic [7:0]  dcnt;
  logic [7:0]  bcc;
  logic [15:0] rem;
  logic        cont;
  logic        hdr_bad;
  logic        bcc_bad;
  logic        tx_valid;
  logic [7:0]  tx_data;
  logic [3:0]  hlen;
  logic [7:0]  rsp;
  logic        rx;
  logic [7:0]  rb;

  assign hlen   = cont ? `SFT_HDR_CONT : `SFT_HDR_FULL;
  assign rsp    = (cnt == 4'h0) ? (cont ? `SFT_CONT : `SFT_FIRST) :
                  (cnt == 4'h3) ? err_num : 8'h00;
  assign rx     = link.a2p_valid;
  assign rb     = link.a2p_data;
  assign rd_req = (state == sft_pkg::PAS_T_FETCH);

  assign link.p2a_valid = tx_valid;
  assign link.p2a_data  = tx_data;

  // ****************************************
  // Frame sequencer
  // ****************************************
  // Wrong DLE or ETX codes drop the exchange silently; header, check byte and zero-length faults get an error number
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state    <= sft_pkg::PAS_IDLE;
      cnt      <= 4'h0;
      dcnt     <= 8'h00;
      bcc      <= 8'h00;
      rem      <= 16'h0000;
      cont     <= 1'b0;
      hdr_bad  <= 1'b0;
      bcc_bad  <= 1'b0;
      tx_valid <= 1'b0;
      tx_data  <= 8'h00;
      rd_db    <= 8'h00;
      rd_addr  <= 16'h0000;
      req_done <= 1'b0;
      err_num  <= 8'h00;
    end else begin
      tx_valid <= 1'b0;
      req_done <= 1'b0;
      unique case (state)
        sft_pkg::PAS_IDLE: begin
          if (rx && rb == `SFT_STX) begin
            tx_valid <= 1'b1;
            tx_data  <= `SFT_DLE;
            cnt      <= 4'h0;
            bcc      <= 8'h00;
            hdr_bad  <= 1'b0;
            bcc_bad  <= 1'b0;
            state    <= sft_pkg::PAS_R_HDR;
          end
        end
        sft_pkg::PAS_R_HDR: begin
          if (rx) begin
            bcc <= bcc ^ rb;
            cnt <= cnt + 4'h1;
            unique case (cnt)
              4'h0: begin
                cont <= (rb == `SFT_CONT);
                if (rb != `SFT_CONT && rb != `SFT_FIRST) hdr_bad <= 1'b1;
              end
              4'h1: if (rb != 8'h00) hdr_bad <= 1'b1;
              4'h2: if (rb != `SFT_CMD_FETCH) hdr_bad <= 1'b1;
              4'h3: if (rb != `SFT_DATA_BLK) hdr_bad <= 1'b1;
              4'h4: rd_db <= rb;
              4'h5: rd_addr <= {8'h00, rb};
              4'h6: rem[15:8] <= rb;
              4'h7: rem[7:0] <= rb;
              default: ;
            endcase
            if (cnt == hlen - 4'h1) begin
              state <= sft_pkg::PAS_R_DLE;
            end
          end
        end
        sft_pkg::PAS_R_DLE: begin
          if (rx) begin
            bcc   <= bcc ^ rb;
            state <= (rb == `SFT_DLE) ? sft_pkg::PAS_R_ETX : sft_pkg::PAS_IDLE;
          end
        end
        sft_pkg::PAS_R_ETX: begin
          if (rx) begin
            bcc <= bcc ^ rb;
            if (rb != `SFT_ETX) begin
              state <= sft_pkg::PAS_IDLE;
            end else begin
              state <= bcc_en ? sft_pkg::PAS_R_BCC : sft_pkg::PAS_TX_ACK;
            end
          end
        end
        sft_pkg::PAS_R_BCC: begin
          if (rx) begin
            bcc_bad <= (rb != bcc);
            state   <= sft_pkg::PAS_TX_ACK;
          end
        end
        sft_pkg::PAS_TX_ACK: begin
          tx_valid <= 1'b1;
          tx_data  <= `SFT_DLE;
          if (hdr_bad) begin
            err_num <= `SFT_ERR_HDR;
          end else if (bcc_bad) begin
            err_num <= `SFT_ERR_BCC;
          end else if (rem == 16'h0000) begin
            err_num <= `SFT_ERR_NODAT;
          end else begin
            err_num <= `SFT_ERR_NONE;
          end
          state <= sft_pkg::PAS_T_STX;
        end
        sft_pkg::PAS_T_STX: begin
          tx_valid <= 1'b1;
          tx_data  <= `SFT_STX;
          cnt      <= 4'h0;
          bcc      <= 8'h00;
          state    <= sft_pkg::PAS_W_ACK1;
        end
        sft_pkg::PAS_W_ACK1: begin
          if (rx) begin
            state <= (rb == `SFT_DLE) ? sft_pkg::PAS_T_HDR : sft_pkg::PAS_IDLE;
          end
        end
        sft_pkg::PAS_T_HDR: begin
          tx_valid <= 1'b1;
          tx_data  <= rsp;
          bcc      <= bcc ^ rsp;
          cnt      <= cnt + 4'h1;
          if (cnt == `SFT_RSP_HDR - 4'h1) begin
            dcnt  <= sft_pkg::chunk_len(rem);
            state <= (err_num != `SFT_ERR_NONE) ? sft_pkg::PAS_T_DLE : sft_pkg::PAS_T_FETCH;
          end
        end
        sft_pkg::PAS_T_FETCH: begin
          if (rd_valid) begin
            tx_valid <= 1'b1;
            tx_data  <= rd_data;
            bcc      <= bcc ^ rd_data;
            rd_addr  <= rd_addr + 16'h0001;
            rem      <= rem - 16'h0001;
            dcnt     <= dcnt - 8'h01;
            if (dcnt == 8'h01) begin
              state <= sft_pkg::PAS_T_DLE;
            end
          end
        end
        sft_pkg::PAS_T_DLE: begin
          tx_valid <= 1'b1;
          tx_data  <= `SFT_DLE;
          bcc      <= bcc ^ `SFT_DLE;
          state    <= sft_pkg::PAS_T_ETX;
        end
        sft_pkg::PAS_T_ETX: begin
          tx_valid <= 1'b1;
          tx_data  <= `SFT_ETX;
          bcc      <= bcc ^ `SFT_ETX;
          state    <= bcc_en ? sft_pkg::PAS_T_BCC : sft_pkg::PAS_W_ACK2;
        end
        sft_pkg::PAS_T_BCC: begin
          tx_valid <= 1'b1;
          tx_data  <= bcc;
          state    <= sft_pkg::PAS_W_ACK2;
        end
        sft_pkg::PAS_W_ACK2: begin
          if (rx) begin
            req_done <= 1'b1;
            state    <= sft_pkg::PAS_IDLE;
          end
        end
        default: state <= sft_pkg::PAS_IDLE;
      endcase
    end
  end

endmodule : sft_passive

// file: rtl/sft_pkg.sv
// Types and shared helpers of the fetch transaction framer
`include "sft_params.svh"

package sft_pkg;

  // ****************************************
  // Active end states
  // ****************************************
  typedef enum logic [3:0] {
    ACT_IDLE   = 4'h0,
    ACT_TX_STX = 4'h1,
    ACT_W_ACK1 = 4'h2,
    ACT_TX_HDR = 4'h3,
    ACT_TX_DLE = 4'h4,
    ACT_TX_ETX = 4'h5,
    ACT_TX_BCC = 4'h6,
    ACT_W_ACK2 = 4'h7,
    ACT_R_STX  = 4'h8,
    ACT_R_HDR  = 4'h9,
    ACT_R_DATA = 4'hA,
    ACT_R_DLE  = 4'hB,
    ACT_R_ETX  = 4'hC,
    ACT_R_BCC  = 4'hD,
    ACT_TX_ACK = 4'hE,
    ACT_FIN    = 4'hF
  } sft_act_state_e;

  // ****************************************
  // Passive end states
  // ****************************************
  typedef enum logic [3:0] {
    PAS_IDLE    = 4'h0,
    PAS_R_HDR   = 4'h1,
    PAS_R_DLE   = 4'h2,
    PAS_R_ETX   = 4'h3,
    PAS_R_BCC   = 4'h4,
    PAS_TX_ACK  = 4'h5,
    PAS_T_STX   = 4'h6,
    PAS_W_ACK1  = 4'h7,
    PAS_T_HDR   = 4'h8,
    PAS_T_FETCH = 4'h9,
    PAS_T_DLE   = 4'hA,
    PAS_T_ETX   = 4'hB,
    PAS_T_BCC   = 4'hC,
    PAS_W_ACK2  = 4'hD
  } sft_pas_state_e;

  // Bytes carried by one response frame
  function automatic logic [7:0] chunk_len(input logic [15:0] rem);
    return (rem > `SFT_CHUNK) ? 8'h80 : rem[7:0];
  endfunction : chunk_len

endpackage : sft_pkg

// file: testbench/serial_fetch_transaction_tb_top.sv
// Bench: active and passive ends joined, plus a passive end fed by a faulty driver
`timescale 1ns/1ns
`include "sft_params.svh"

module serial_fetch_transaction_tb_top;
  logic        clk = 0;
  logic        rst = 1;
  logic        bcc_en = 0;
  logic        bcc_en_b = 0;
  logic        start = 0;
  logic [7:0]  req_db = 0;
  logic [7:0]  req_off = 0;
  logic [15:0] req_len = 0;
  logic        rd_valid = 0;
  logic [7:0]  rd_data = 0;
  logic        busy, data_valid, done, proto_err, rd_req, req_done;
  logic [7:0]  data, err_num, err_num_p, rd_db, err_num_b, bx, ev;
  logic [15:0] rd_addr;
  logic [15:0] lens [5] = '{16'h0002, 16'h012C, 16'h0080, 16'h0000, 16'h0081};
  logic [7:0]  exp_q[$], err_q[$], rsp_q[$], exp_b[$], len_q[$];
  logic [31:0] rnd;
  integer      seed = 32'h0ea0_767a;
  int          num_errors = 0;
  int          n_compared = 0;
  int          n_rsp = 0;
  int          n_take = 0;
  int          t;
  sft_link_if link();
  sft_link_if link_b();
  always #2 clk = ~clk;
  sft_active sft_active_inst (.clk(clk), .rst(rst), .link(link), .bcc_en(bcc_en), .start(start),
    .req_db(req_db), .req_off(req_off), .req_len(req_len), .busy(busy), .data_valid(data_valid),
    .data(data), .done(done), .err_num(err_num), .proto_err(proto_err));
  sft_passive sft_passive_inst (.clk(clk), .rst(rst), .link(link), .bcc_en(bcc_en), .rd_req(rd_req),
    .rd_db(rd_db), .rd_addr(rd_addr), .rd_valid(rd_valid), .rd_data(rd_data), .req_done(req_done),
    .err_num(err_num_p));
  // Faulty requests go to a second passive end; its store never answers
  sft_passive sft_passive_inst_b (.clk(clk), .rst(rst), .link(link_b), .bcc_en(bcc_en_b), .rd_req(),
    .rd_db(), .rd_addr(), .rd_valid(1'b0), .rd_data(8'h00), .req_done(), .err_num(err_num_b));
  sft_chk sft_chk_inst (.clk(clk), .rst(rst), .a2p_valid(link.a2p_valid), .a2p_data(link.a2p_data),
    .p2a_valid(link.p2a_valid), .p2a_data(link.p2a_data));
  // ********
  // Store model and checks
  // ********
  // Bit 4 cleared so data never mimics the end code pair
  function automatic logic [7:0] mem(input logic [7:0] d, input logic [15:0] a);
    return (a[7:0] ^ d ^ 8'h5A) & 8'hEF;
  endfunction : mem
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp8
  task automatic end_of_test;
    $display("compared=%0d errors=%0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test
  always @(posedge clk) begin
    #1;
    rnd = $random(seed);
    rd_valid <= rnd[0];
    rd_data <= mem(rd_db, rd_addr);
  end
  always @(posedge clk) begin
    if (req_done === 1'b1) n_rsp++;
    if (rd_req === 1'b1 && rd_valid === 1'b1) n_take++;
    if (data_valid === 1'b1) cmp8(data, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);
    if (done === 1'b1) begin
      ev = err_q.size() > 0 ? err_q.pop_front() : 8'hxx;
      cmp8(err_num, ev);
      cmp8(err_num_p, ev);
      cmp8(8'(n_rsp), rsp_q.size() > 0 ? rsp_q.pop_front() : 8'hxx);
      cmp8(8'(n_take), len_q.size() > 0 ? len_q.pop_front() : 8'hxx);
      cmp8({7'h00, proto_err}, 8'h00);
      cmp8({7'h00, busy}, 8'h00);
      n_rsp = 0;
      n_take = 0;
    end
    if (link_b.p2a_valid === 1'b1) cmp8(link_b.p2a_data, exp_b.size() > 0 ? exp_b.pop_front() : 8'hxx);
  end
  // ********
  // Drivers
  // ********
  task automatic fetch(input logic [15:0] len, input logic bb);
    int i;
    logic [31:0] r;
    r = $random(seed);
    bcc_en = bb;
    req_db = {4'h0, r[3:0]};
    req_off = r[15:8];
    req_len = len;
    start = 1;
    for (i = 0; i < len; i++) exp_q.push_back(mem(req_db, 16'(req_off) + 16'(i)));
    err_q.push_back(len == 0 ? `SFT_ERR_NODAT : `SFT_ERR_NONE);
    rsp_q.push_back(len == 0 ? 8'h01 : 8'((len + 127) / 128));
    len_q.push_back(8'(len));
    @(posedge clk);
    #1;
    start = 0;
    cmp8({7'h00, busy}, 8'h01);
    for (i = 0; i < 6000; i++) begin
      @(posedge clk);
      #1;
      if (done === 1'b1) break;
    end
    if (i == 6000) num_errors++;
  endtask : fetch
  task automatic tx_b(input logic [7:0] b);
    link_b.a2p_valid = 1;
    link_b.a2p_data = b;
    bx ^= b;
    @(posedge clk);
    #1;
  endtask : tx_b
  task automatic rel_b;
    link_b.a2p_valid = 0;
    link_b.a2p_data = ~link_b.a2p_data;
  endtask : rel_b
  task automatic wait_b(input int n);
    int k;
    for (k = 0; k < 200 && n > 0; k++) begin
      @(posedge clk);
      if (link_b.p2a_valid === 1'b1) n--;
    end
    #1;
    if (n > 0) num_errors++;
  endtask : wait_b
  task automatic frame_b(input logic [7:0] h3, input logic [7:0] ln, input logic bb, input logic [7:0] bad,
                         input logic prot, input logic [7:0] err);
    logic [7:0] hdr [10];
    int i;
    hdr = '{8'h00, 8'h00, h3, 8'h44, 8'h01, 8'h00, 8'h00, ln, 8'hFF, 8'hFF};
    bcc_en_b = bb;
    exp_b.push_back(`SFT_DLE);
    if (!prot) begin
      exp_b = {exp_b, `SFT_DLE, `SFT_STX, 8'h00, 8'h00, 8'h00, err, `SFT_DLE, `SFT_ETX};
      if (bb) exp_b.push_back(err ^ 8'h13);
    end
    tx_b(`SFT_STX);
    rel_b;
    wait_b(1);
    bx = 0;
    for (i = 0; i < 10; i++) tx_b(hdr[i]);
    tx_b(`SFT_DLE);
    tx_b(prot ? 8'h55 : `SFT_ETX);
    if (bb) tx_b(bx ^ bad);
    rel_b;
    if (prot) begin
      repeat (40) @(posedge clk);
      #1;
    end else begin
      wait_b(2);
      tx_b(`SFT_DLE);
      rel_b;
      wait_b(bb ? 7 : 6);
      tx_b(`SFT_DLE);
      rel_b;
      cmp8(err_num_b, err);
    end
  endtask : frame_b
  initial begin
    #80000;
    num_errors++;
    end_of_test;
  end
  initial begin
    link_b.a2p_valid = 0;
    link_b.a2p_data = 8'h00;
    repeat (12) @(posedge clk);
    #1;
    rst = 0;
    @(posedge clk);
    #1;
    for (t = 0; t < 5; t++) fetch(lens[t], t[0]);
    frame_b(8'h41, 8'h04, 1'b0, 8'h00, 1'b0, `SFT_ERR_HDR);
    frame_b(8'h45, 8'h04, 1'b1, 8'h5A, 1'b0, `SFT_ERR_BCC);
    frame_b(8'h45, 8'h04, 1'b0, 8'h00, 1'b1, 8'h00);
    frame_b(8'h45, 8'h00, 1'b0, 8'h00, 1'b0, `SFT_ERR_NODAT);
    cmp8(8'(exp_q.size() + exp_b.size()), 8'h00);
    end_of_test;
  end
endmodule : serial_fetch_transaction_tb_top

// file: testbench/sft_chk.sv
// Link checker: frame order and acknowledge timing on the byte link
`timescale 1ns/1ns
`include "sft_params.svh"

module sft_chk (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // Link
  input wire logic       a2p_valid,
  input wire logic [7:0] a2p_data,
  input wire logic       p2a_valid,
  input wire logic [7:0] p2a_data
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ********
  // Frame marks
  // ********
  // Header bytes may equal STX, so a start needs a quiet link or a DLE ack before it
  logic       a_q;
  logic       p_q;
  logic [7:0] ad_q;
  logic [7:0] ad_q2;
  logic [7:0] pd_q;
  logic       req_sta;
  logic       rsp_sta;
  logic       req_end;
  logic       rsp_end;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {a_q, p_q, ad_q, ad_q2, pd_q} <= '0;
    end else begin
      {a_q, p_q} <= {a2p_valid, p2a_valid};
      {ad_q, ad_q2, pd_q} <= {a2p_data, ad_q, p2a_data};
    end
  end
  // Continuation start follows straight on from the ack that closed the last response
  assign req_sta = a2p_valid && a2p_data == `SFT_STX && (!a_q || ad_q == `SFT_DLE) && !p_q;
  assign rsp_sta = p2a_valid && p2a_data == `SFT_STX && p_q && pd_q == `SFT_DLE && !a_q;
  assign req_end = a2p_valid && a2p_data == `SFT_ETX && a_q && ad_q == `SFT_DLE
                   && (ad_q2 == 8'hFF || ad_q2 == 8'h44);
  assign rsp_end = p2a_valid && p2a_data == `SFT_ETX && p_q && pd_q == `SFT_DLE;
  // ********
  // Checks
  // ********
  stx_ack_a: assert property (req_sta |=> p2a_valid && p2a_data == `SFT_DLE)
    else $error("start code not acknowledged");
  hdr_wait_a: assert property (req_sta |=> !a2p_valid ##1 !a2p_valid ##1 a2p_valid)
    else $error("header not sent right after acknowledge");
  cont_hdr_a: assert property (req_sta ##3 (a2p_valid && a2p_data == 8'hFF) |->
    ##1 a2p_data == 8'h00 ##1 a2p_data == 8'h45 ##1 a2p_data == 8'h44 ##1 a2p_data == `SFT_DLE)
    else $error("bad continuation header");
  first_hdr_a: assert property (req_sta ##3 (a2p_valid && a2p_data == 8'h00) |->
    ##1 a2p_data == 8'h00 ##1 a2p_data == 8'h45 ##1 a2p_data == 8'h44 ##1 a2p_valid [*4]
    ##1 a2p_data == 8'hFF ##1 a2p_data == 8'hFF ##1 a2p_data == `SFT_DLE ##1 a2p_data == `SFT_ETX)
    else $error("bad first request header");
  rsp_hdr_a: assert property (rsp_sta |=> a2p_valid && a2p_data == `SFT_DLE ##2 p2a_valid
    ##1 (p2a_valid && p2a_data == 8'h00) [*2] ##1 p2a_valid)
    else $error("bad response header");
  err_nodata_a: assert property (rsp_sta ##6 (p2a_valid && p2a_data != 8'h00) |=>
    p2a_valid && p2a_data == `SFT_DLE ##1 p2a_valid && p2a_data == `SFT_ETX)
    else $error("data after nonzero error number");
  // Upper bound covers the extra check byte
  req_ack_a: assert property (req_end |-> ##[1:3] (p2a_valid && p2a_data == `SFT_DLE))
    else $error("request end not acknowledged");
  rsp_ack_a: assert property (rsp_end |-> ##[1:3] (a2p_valid && a2p_data == `SFT_DLE))
    else $error("response end not acknowledged");
  cont_cv: cover property (req_sta ##3 (a2p_valid && a2p_data == 8'hFF));
endmodule : sft_chk
